// >>> design/gpio_port_irq_trigger.sv
/*
  eight-pin gpio port: direction/mode, adc and dma triggers, per-pin interrupt detection,
  raw/masked status, summary or discrete interrupt lines, lock and commit protection.
  assumes a single-cycle register master on ref_clk_i; pins are asynchronous to the clock.
  limitation: level types pulse the adc and dma triggers every cycle the level holds.
  limitation: a commit lasts only until the next write to the lock register.
*/
`timescale 1ns/1ps
`include "gpio_port_consts.svh"

module gpio_port_irq_trigger
  import gpio_port_pkg::*;
(
  input  wire logic                 ref_clk_i,
  input  wire logic                 reset_i,
  input  wire logic [`ADDR_W-1:0]   addr_i,
  input  wire logic [`DATA_W-1:0]   wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic      [`DATA_W-1:0]   rdata_o,
  input  wire logic [`NPIN-1:0]     pin_i,
  output logic      [`NPIN-1:0]     pin_o,
  output logic      [`NPIN-1:0]     pin_oe_o,
  input  wire logic [`NPIN-1:0]     periph_out_i,
  input  wire logic [`NPIN-1:0]     periph_oe_i,
  output logic      [`NPIN-1:0]     periph_in_o,
  input  wire logic                 dma_done_i,
  output logic                      adc_trigger_o,
  output logic                      dma_trigger_o,
  output logic                      irq_o,
  output logic      [`NPIN-1:0]     pin_irq_o
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchroniser and edge history
  logic [`NPIN-1:0]   sync1_q;
  logic [`NPIN-1:0]   sync2_q;
  logic [`NPIN-1:0]   prev_q;
  // configuration and status, one flop set per concern
  logic [`NPIN-1:0]   out_q;
  dir_mode_t          dir_q [`NPIN];
  det_type_t          type_q [`NPIN];
  logic [`NPIN-1:0]   adc_en_q;
  logic [`NPIN-1:0]   dma_en_q;
  logic [`NSRC-1:0]   irq_en_q;
  logic [`NSRC-1:0]   raw_q;
  logic [`NPIN-1:0]   locked_q;
  logic               unlocked_q;
  logic [`NPIN-1:0]   commit_q;
  logic [1:0]         dir_sel_q;
  logic               discrete_q;
  logic [`NPIN-1:0]   detect;
  logic [`NPIN-1:0]   level_mode;
  logic [`NPIN-1:0]   writable;
  logic [`NSRC-1:0]   masked;
  logic               wr_dirset;
  logic               wr_typeset;
  logic               wr_irqclr;

  // two flops tame metastability; prev_q holds the last settled level for edges
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      prev_q  <= 8'h00;
    end
    else
    begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-pin detection and pin steering
  // strobe decodes shared by the per-pin logic
  assign wr_dirset  = wr_i && (addr_i == `OFF_DIR_SET);
  assign wr_typeset = wr_i && (addr_i == `OFF_TYPE_SET);
  assign wr_irqclr  = wr_i && (addr_i == `OFF_IRQ_CLR);
  // locked pins take new direction only while unlocked and committed
  assign writable   = ~locked_q | (commit_q & {`NPIN{unlocked_q}});

  genvar g;
  generate
    for (g = 0; g < `NPIN; g++)
    begin : g_pin
      // illegal type codes detect nothing instead of firing at random
      always_comb
      begin
        unique case (type_q[g])
          DET_FALL: detect[g] = prev_q[g] & ~sync2_q[g];
          DET_RISE: detect[g] = ~prev_q[g] & sync2_q[g];
          DET_BOTH: detect[g] = prev_q[g] ^ sync2_q[g];
          DET_LOW:  detect[g] = ~sync2_q[g];
          DET_HIGH: detect[g] = sync2_q[g];
          default:  detect[g] = 1'b0;
        endcase
        level_mode[g] = (type_q[g] == DET_LOW) || (type_q[g] == DET_HIGH);
      end

      // peripheral drive passes straight through so it keeps its own timing
      always_comb
      begin
        unique case (dir_q[g])
          DIR_OUT:
          begin
            pin_o[g]    = out_q[g];
            pin_oe_o[g] = 1'b1;
          end
          peripheral_control_setting:
          begin
            pin_o[g]    = periph_out_i[g];
            pin_oe_o[g] = periph_oe_i[g];
          end
          default:
          begin
            pin_o[g]    = 1'b0;
            pin_oe_o[g] = 1'b0;
          end
        endcase
      end
      // other pins read zero so a peripheral never sees plain gpio traffic
      assign periph_in_o[g] = (dir_q[g] == peripheral_control_setting) ? sync2_q[g] : 1'b0;

      // a locked pin keeps its setting until unlock and commit both happened
      always_ff @(posedge ref_clk_i or posedge reset_i)
      begin
        if (reset_i)
          dir_q[g] <= dir_mode_t'(`DIR_RST);
        else if (wr_dirset && wdata_i[g] && writable[g])
          dir_q[g] <= dir_mode_t'(dir_sel_q);
      end

      // retyping under a moving input can latch a spurious event
      always_ff @(posedge ref_clk_i or posedge reset_i)
      begin
        if (reset_i)
          type_q[g] <= det_type_t'(`TYPE_RST);
        else if (wr_typeset && wdata_i[g])
          type_q[g] <= det_type_t'(wdata_i[10:8]);
      end

      // set beats clear; level mode drops when the level goes away
      always_ff @(posedge ref_clk_i or posedge reset_i)
      begin
        if (reset_i)
          raw_q[g] <= 1'b0;
        else if (detect[g])
          raw_q[g] <= 1'b1;
        else if (wr_irqclr && wdata_i[g])
          raw_q[g] <= 1'b0;
        else if (level_mode[g])
          raw_q[g] <= 1'b0;
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // dma activity source
  // the pulse already lives on this clock, so it needs no synchroniser
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      raw_q[`DMA_SRC_BIT] <= 1'b0;
    else if (dma_done_i)
      raw_q[`DMA_SRC_BIT] <= 1'b1;
    else if (wr_irqclr && wdata_i[`DMA_SRC_BIT])
      raw_q[`DMA_SRC_BIT] <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // control registers
  // enables move by mask so one pin's update never disturbs another
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      out_q      <= 8'h00;
      adc_en_q   <= 8'h00;
      dma_en_q   <= 8'h00;
      irq_en_q   <= 9'h000;
      dir_sel_q  <= `DIR_RST;
      discrete_q <= 1'b0;
    end
    else if (wr_i)
    begin
      unique case (addr_i)
        // upper byte masks the lower, so pins left out keep their level
        `OFF_DATA_OUT: out_q      <= wdata_i[15:8] & wdata_i[7:0] | out_q & ~wdata_i[15:8];
        `OFF_DIR_SEL:  dir_sel_q  <= wdata_i[1:0];
        `OFF_ADC_EN:   adc_en_q   <= adc_en_q | wdata_i[7:0];
        `OFF_ADC_DIS:  adc_en_q   <= adc_en_q & ~wdata_i[7:0];
        `OFF_DMA_EN:   dma_en_q   <= dma_en_q | wdata_i[7:0];
        `OFF_DMA_DIS:  dma_en_q   <= dma_en_q & ~wdata_i[7:0];
        `OFF_IRQ_EN:   irq_en_q   <= irq_en_q | wdata_i[8:0];
        `OFF_IRQ_DIS:  irq_en_q   <= irq_en_q & ~wdata_i[8:0];
        `OFF_DISCRETE: discrete_q <= wdata_i[0];
        default:       ;
      endcase
    end
  end

  // key write opens one commit window; any other lock write closes it again
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      locked_q   <= `LOCKED_PINS_RST;
      unlocked_q <= 1'b0;
      commit_q   <= 8'h00;
    end
    else if (wr_i && (addr_i == `OFF_LOCK))
    begin
      // every lock write drops old commits, so each unlock needs a fresh commit
      unlocked_q <= (wdata_i == `LOCK_KEY);
      commit_q   <= 8'h00;
    end
    else if (wr_i && (addr_i == `OFF_COMMIT) && unlocked_q)
      commit_q <= wdata_i[7:0] & locked_q;
  end

  //////////////////////////////////////////////////////////////////////////////
  // triggers and interrupt outputs
  // triggers follow detection and their own adc/dma enables; the interrupt enable does not gate them
  assign masked = raw_q & irq_en_q;

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      adc_trigger_o <= 1'b0;
      dma_trigger_o <= 1'b0;
      irq_o         <= 1'b0;
      pin_irq_o     <= 8'h00;
    end
    else
    begin
      adc_trigger_o <= |(detect & adc_en_q);
      dma_trigger_o <= |(detect & dma_en_q);
      irq_o         <= |masked;
      // discrete gives one line per pin; otherwise everything lands on line 0
      pin_irq_o     <= discrete_q ? masked[7:0] : {7'h00, |masked};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port, data valid the cycle after the strobe
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      rdata_o <= 32'h0000_0000;
    else if (rd_i)
    begin
      unique case (addr_i)
        `OFF_DATA_IN:  rdata_o <= {24'h0, sync2_q & wdata_i[7:0]};
        `OFF_DATA_OUT: rdata_o <= {24'h0, out_q};
        `OFF_DIR_SEL:  rdata_o <= {30'h0, dir_sel_q};
        `OFF_DIR_GET:  rdata_o <= {30'h0, dir_q[wdata_i[2:0]]};
        `OFF_ADC_EN:   rdata_o <= {24'h0, adc_en_q};
        `OFF_DMA_EN:   rdata_o <= {24'h0, dma_en_q};
        `OFF_IRQ_EN:   rdata_o <= {23'h0, irq_en_q};
        `OFF_RAW_STAT: rdata_o <= {23'h0, raw_q};
        `OFF_MSK_STAT: rdata_o <= {23'h0, masked};
        `OFF_TYPE_GET: rdata_o <= {28'h0, discrete_q, type_q[wdata_i[2:0]]};
        `OFF_LOCK:     rdata_o <= {31'h0, ~unlocked_q};
        `OFF_COMMIT:   rdata_o <= {24'h0, commit_q};
        `OFF_DISCRETE: rdata_o <= {31'h0, discrete_q};
        default:       rdata_o <= 32'h0000_0000;
      endcase
    end
    else
      // idle cycles return zero so a stale word is never taken for a fresh read
      rdata_o <= 32'h0000_0000;
  end

endmodule

// >>> design/gpio_port_consts.svh
/*
  register offsets, field positions, reset values and encodings for the gpio port.
  assumes inclusion by design and bench files; definitions, no logic.
*/
`ifndef GPIO_PORT_CONSTS_SVH
`define GPIO_PORT_CONSTS_SVH

`define ADDR_W            8
`define DATA_W            32
`define NPIN              8
`define NSRC              9
`define DMA_SRC_BIT       8

`define OFF_DATA_IN       8'h00
`define OFF_DATA_OUT      8'h04
`define OFF_DIR_SET       8'h08
`define OFF_DIR_SEL       8'h0c
`define OFF_DIR_GET       8'h10
`define OFF_ADC_EN        8'h14
`define OFF_ADC_DIS       8'h18
`define OFF_DMA_EN        8'h1c
`define OFF_DMA_DIS       8'h20
`define OFF_IRQ_EN        8'h24
`define OFF_IRQ_DIS       8'h28
`define OFF_IRQ_CLR       8'h2c
`define OFF_RAW_STAT      8'h30
`define OFF_MSK_STAT      8'h34
`define OFF_TYPE_SET      8'h38
`define OFF_TYPE_GET      8'h3c
`define OFF_LOCK          8'h40
`define OFF_COMMIT        8'h44
`define OFF_DMA_EVT       8'h48
`define OFF_DISCRETE      8'h4c

`define LOCK_KEY          32'h5a5a_c3c3
`define LOCKED_PINS_RST   8'hc0
`define DIR_RST           2'h0
`define TYPE_RST          3'h0

`endif

// >>> design/gpio_port_pkg.sv
/*
  types shared by the gpio port design and its bench.
  assumes the consts header sits beside it.
*/
package gpio_port_pkg;
  typedef enum logic [1:0] {
    DIR_IN  = 2'h0,
    DIR_OUT = 2'h1,
    peripheral_control_setting = 2'h2
  } dir_mode_t;

  typedef enum logic [2:0] {
    DET_FALL  = 3'h0,
    DET_RISE  = 3'h1,
    DET_BOTH  = 3'h2,
    DET_LOW   = 3'h3,
    DET_HIGH  = 3'h4
  } det_type_t;
endpackage

// >>> dv/gpio_port_irq_trigger_monitor.sv
/* port checker for the gpio port.
   assumes it is bound onto gpio_port_irq_trigger. */
`timescale 1ns/1ps
`include "gpio_port_consts.svh"
module gpio_port_irq_trigger_monitor(
  input wire logic               ref_clk_i,
  input wire logic               reset_i,
  input wire logic [`ADDR_W-1:0] addr_i,
  input wire logic               wr_i,
  input wire logic               rd_i,
  input wire logic [`DATA_W-1:0] rdata_o,
  input wire logic [`NPIN-1:0]   pin_o,
  input wire logic [`NPIN-1:0]   pin_oe_o,
  input wire logic [`NPIN-1:0]   periph_out_i,
  input wire logic [`NPIN-1:0]   periph_oe_i,
  input wire logic               adc_trigger_o,
  input wire logic               dma_trigger_o,
  input wire logic               irq_o,
  input wire logic [`NPIN-1:0]   pin_irq_o
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);
  // flags remember which enable and commit registers were ever written since reset
  logic adc_q, dma_q, ien_q, cmt_q;
  always_ff @(posedge ref_clk_i or posedge reset_i)
    if (reset_i)
    begin
      {adc_q, dma_q, ien_q, cmt_q} <= '0;
    end
    else if (wr_i)
    begin
      adc_q <= adc_q | (addr_i == `OFF_ADC_EN);
      dma_q <= dma_q | (addr_i == `OFF_DMA_EN);
      ien_q <= ien_q | (addr_i == `OFF_IRQ_EN);
      cmt_q <= cmt_q | (addr_i == `OFF_COMMIT);
    end
  ////////////////////////////////////////
  a_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == '0)
    else $error("read data outside its slot");
  a_adc_needs_en: assert property (!adc_q |-> !adc_trigger_o)
    else $error("adc trigger without enable");
  a_dma_needs_en: assert property (!dma_q |-> !dma_trigger_o)
    else $error("dma trigger without enable");
  a_irq_needs_en: assert property (!ien_q |-> !irq_o && pin_irq_o == '0)
    else $error("interrupt without enable");
  a_line_implies_irq: assert property (|pin_irq_o |-> irq_o)
    else $error("pin line without port interrupt");
  a_oe_after_write: assert property ($changed(pin_oe_o) |-> $past(wr_i) || $changed(periph_oe_i))
    else $error("enable moved without cause");
  a_out_after_write: assert property ($changed(pin_o) |-> $past(wr_i) || $changed(periph_out_i))
    else $error("pin value moved without cause");
  a_lock_holds: assert property (!cmt_q |-> pin_oe_o[7:6] == 2'h0)
    else $error("locked pin reconfigured");
  c_irq: cover property ($rose(irq_o));
  c_adc: cover property (adc_trigger_o);
  c_dma: cover property (dma_trigger_o);
  c_line1: cover property (pin_irq_o[1]);
endmodule
bind gpio_port_irq_trigger gpio_port_irq_trigger_monitor gpio_port_irq_trigger_monitor_inst(.*);

// >>> dv/pin_partner.sv
/* far-side drivers of the eight pins.
   assumes the bench commands the idle levels. */
`timescale 1ns/1ps
module pin_partner #(parameter int LAG = 3)
(
  input  wire logic [7:0] drv_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] lvl_i,
  output wire logic [7:0] pad_o
);
  // pads taken as configured; lag keeps edges off the clock
  assign #(LAG) pad_o = (oe_i & drv_i) | (~oe_i & lvl_i);
endmodule

// >>> dv/tb_top.sv
/* self-checking bench for the gpio port.
   assumes the design header and package compile first. */
`timescale 1ns/1ps
`include "gpio_port_consts.svh"
module tb_top;
  logic ref_clk_i, reset_i, wr, rd, rd_d, dma_done, adc_t, dma_t, irq;
  logic [7:0] addr, lvl, pout, poe, pad, pin_o, pin_oe, pin_irq, per_in;
  logic [31:0] wdata, rdata, exp_q[$];
  int error_cnt, tests_run, adc_n, dma_n, cyc, seed, p, a0, d0;
  gpio_port_irq_trigger gpio_port_irq_trigger_inst(.ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pin_i(pad), .pin_o(pin_o), .pin_oe_o(pin_oe),
    .periph_out_i(pout), .periph_oe_i(poe), .periph_in_o(per_in), .dma_done_i(dma_done), .adc_trigger_o(adc_t),
    .dma_trigger_o(dma_t), .irq_o(irq), .pin_irq_o(pin_irq));
  pin_partner pin_partner_inst(.drv_i(pin_o), .oe_i(pin_oe), .lvl_i(lvl), .pad_o(pad));
  initial
  begin
    ref_clk_i = 0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      error_cnt++;
    end
  endtask
  task automatic results;
    if (error_cnt == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    if (!w)
      exp_q.push_back(e);
    @(posedge ref_clk_i);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic gap;
    repeat (6) @(posedge ref_clk_i);
  endtask
  ////////////////////////////////////////
  always @(posedge ref_clk_i)
  begin
    rd_d <= rd;
    adc_n <= adc_n + adc_t;
    dma_n <= dma_n + dma_t;
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      results();
    end
  end
  // read data stand only in the cycle after the strobe
  always @(negedge ref_clk_i)
    if (rd_d)
      chk(rdata, exp_q.pop_front());
  initial
  begin
    seed = 32'h39b1abd1;
    {wr, rd, rd_d, dma_done, addr, wdata, adc_n, dma_n, cyc} = '0;
    lvl = $random(seed);
    pout = $random(seed);
    poe = $random(seed);
    reset_i = 1;
    repeat (8) @(posedge ref_clk_i);
    reset_i <= 0;
    gap();
    p = $random(seed);
    xfer(0, `OFF_DATA_IN, p, lvl & p[7:0]);
    xfer(0, 8'h80, 0, 0);
    xfer(1, `OFF_DIR_SEL, 1, 0);
    xfer(1, `OFF_DIR_SET, 8'h80, 0);
    xfer(0, `OFF_DIR_GET, 7, 0);
    xfer(1, `OFF_LOCK, `LOCK_KEY, 0);
    xfer(1, `OFF_COMMIT, 8'h80, 0);
    xfer(1, `OFF_DIR_SET, 8'h80, 0);
    xfer(0, `OFF_DIR_GET, 7, 1);
    xfer(1, `OFF_DATA_OUT, 32'h80ff, 0);
    gap();
    chk(pin_o, 8'h80);
    chk(pin_oe, 8'h80);
    xfer(0, `OFF_DATA_OUT, 0, 8'h80);
    xfer(0, `OFF_DATA_IN, 8'h81, {24'h0, 1'b1, 6'h0, lvl[0]});
    for (int m = 0; m < 3; m++)
    begin
      p = $unsigned($random(seed)) % 6;
      xfer(1, `OFF_DIR_SEL, m, 0);
      xfer(1, `OFF_DIR_SET, 32'(1 << p), 0);
      xfer(0, `OFF_DIR_GET, p, m);
      chk(pin_oe[p], m == 2 ? poe[p] : m == 1);
      gap();
      chk(per_in[p], m == 2 ? (poe[p] ? pout[p] : lvl[p]) : 1'b0);
    end
    xfer(1, `OFF_DIR_SEL, 0, 0);
    xfer(1, `OFF_DIR_SET, 8'h7f, 0);
    for (int t = 0; t < 5; t++)
    begin
      lvl[0] <= (t == 0 || t == 3);
      gap();
      xfer(1, `OFF_TYPE_SET, (t << 8) | 1, 0);
      xfer(1, `OFF_IRQ_CLR, 9'h1ff, 0);
      lvl[0] <= !(t == 0 || t == 3);
      gap();
      xfer(0, `OFF_RAW_STAT, 0, 1);
      xfer(0, `OFF_TYPE_GET, 0, t);
    end
    lvl[0] <= 0;
    gap();
    xfer(1, `OFF_TYPE_SET, 32'h101, 0);
    xfer(1, `OFF_ADC_EN, 1, 0);
    xfer(1, `OFF_DMA_EN, 1, 0);
    xfer(1, `OFF_IRQ_EN, 9'h101, 0);
    xfer(1, `OFF_IRQ_CLR, 9'h1ff, 0);
    a0 = adc_n;
    d0 = dma_n;
    lvl[0] <= 1;
    gap();
    chk(adc_n - a0, 1);
    chk(dma_n - d0, 1);
    chk(irq, 1);
    chk(pin_irq, 1);
    xfer(0, `OFF_MSK_STAT, 0, 1);
    dma_done <= 1;
    @(posedge ref_clk_i);
    dma_done <= 0;
    xfer(0, `OFF_RAW_STAT, 0, 9'h101);
    xfer(1, `OFF_IRQ_CLR, 1, 0);
    xfer(0, `OFF_RAW_STAT, 0, 9'h100);
    xfer(1, `OFF_IRQ_DIS, 9'h100, 0);
    gap();
    chk(irq, 0);
    xfer(1, `OFF_ADC_DIS, 1, 0);
    xfer(1, `OFF_DMA_DIS, 1, 0);
    a0 = adc_n;
    d0 = dma_n;
    lvl[0] <= 0;
    gap();
    lvl[0] <= 1;
    gap();
    chk(adc_n - a0, 0);
    chk(dma_n - d0, 0);
    xfer(0, `OFF_MSK_STAT, 0, 1);
    chk(irq, 1);
    xfer(1, `OFF_IRQ_EN, 2, 0);
    lvl[1] <= 1;
    gap();
    lvl[1] <= 0;
    gap();
    chk(pin_irq, 1);
    xfer(1, `OFF_DISCRETE, 1, 0);
    gap();
    chk(pin_irq, 3);
    xfer(0, `OFF_TYPE_GET, 0, 9);
    repeat (2) @(posedge ref_clk_i);
    chk(exp_q.size(), 0);
    results();
  end
endmodule
